// >>> core/dual_wiper_serial_shift_port.sv
// Dual wiper serial load port: link shifting and wiper tap update
`timescale 1ns/1ns
`default_nettype none

module dual_wiper_serial_shift_port #(
    parameter int CODE_W = pot_port_pkg::CODE_W,
    parameter int TAP_COUNT = pot_port_pkg::TAP_COUNT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_clk,
    input wire logic serial_enable,
    input wire logic serial_data,
    output logic cascade_out,
    output logic [7:0] wiper_zero_code,
    output logic [7:0] wiper_one_code,
    output logic [255:0] wiper_zero_terminal,
    output logic [255:0] wiper_one_terminal,
    output logic stack_select_bit,
    output logic [7:0] stacked_code,
    output logic stacked_from_one,
    output logic load_done
);

    ////////////////////////////////////////////////////////////////
    // Elaboration check: the tap decode is fixed at eight bits
    if (CODE_W != pot_port_pkg::CODE_W || TAP_COUNT != (1 << CODE_W)) begin : g_bad_width
        initial begin
            $error("code width must be 8 and tap count 256");
        end
    end

    logic link_rst_b;
    logic enable_sync;
    logic enable_prev_ff;
    logic enable_fall;
    logic [16:0] shift_q;
    logic [7:0] nxt_zero_code;
    logic [7:0] nxt_one_code;
    logic nxt_stack;
    logic [7:0] zero_code_ff;
    logic [7:0] one_code_ff;
    logic stack_ff;
    logic [7:0] stacked_code_ff;
    logic stacked_from_one_ff;
    logic [255:0] zero_tap_ff;
    logic [255:0] one_tap_ff;
    logic load_done_ff;

    ////////////////////////////////////////////////////////////////
    // Reset carried into the serial clock domain
    level_sync u_link_rst_sync (
        .dst_clk(serial_clk),
        .async_in(rst_b),
        .sync_out(link_rst_b)
    );

    // Enable level carried into the system clock domain
    level_sync u_enable_sync (
        .dst_clk(clk),
        .async_in(serial_enable),
        .sync_out(enable_sync)
    );

    ////////////////////////////////////////////////////////////////
    // Link side shift register and cascade output
    link_shift_register u_shift (
        .serial_clk(serial_clk),
        .link_rst_b(link_rst_b),
        .serial_enable(serial_enable),
        .serial_data(serial_data),
        .shift_q(shift_q),
        .cascade_out(cascade_out)
    );

    ////////////////////////////////////////////////////////////////
    // Falling edge of the synchronised enable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_prev_ff <= 1'b0;
        end else begin
            enable_prev_ff <= enable_sync;
        end
    end

    assign enable_fall = enable_prev_ff & ~enable_sync;

    ////////////////////////////////////////////////////////////////
    // Field extraction; MSB of each code sits at the lower position
    always_comb begin
        nxt_stack = shift_q[pot_port_pkg::STACK_POS];
        nxt_one_code = '0;
        nxt_zero_code = '0;
        for (int i = 0; i < pot_port_pkg::CODE_W; i++) begin
            nxt_one_code[7 - i] = shift_q[pot_port_pkg::WIPER_ONE_MSB_POS + i];
            nxt_zero_code[7 - i] = shift_q[pot_port_pkg::WIPER_ZERO_MSB_POS + i];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Wiper codes load only on enable fall; the register is frozen
    // by then, so the multi-bit read across domains is safe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            zero_code_ff <= pot_port_pkg::WIPER_RESET;
            one_code_ff <= pot_port_pkg::WIPER_RESET;
            stack_ff <= pot_port_pkg::STACK_RESET;
        end else if (enable_fall) begin
            zero_code_ff <= nxt_zero_code;
            one_code_ff <= nxt_one_code;
            stack_ff <= nxt_stack;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Stacked output selector follows the loaded stack bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stacked_code_ff <= pot_port_pkg::WIPER_RESET;
            stacked_from_one_ff <= pot_port_pkg::STACK_RESET;
        end else if (enable_fall) begin
            stacked_code_ff <= nxt_stack ? nxt_one_code : nxt_zero_code;
            stacked_from_one_ff <= nxt_stack;
        end
    end

    ////////////////////////////////////////////////////////////////
    // One-hot tap select per wiper, one flop per tap
    for (genvar t = 0; t < TAP_COUNT; t++) begin : g_tap
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                zero_tap_ff[t] <= (pot_port_pkg::WIPER_RESET == 8'(t));
                one_tap_ff[t] <= (pot_port_pkg::WIPER_RESET == 8'(t));
            end else if (enable_fall) begin
                zero_tap_ff[t] <= (nxt_zero_code == 8'(t));
                one_tap_ff[t] <= (nxt_one_code == 8'(t));
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // One-cycle marker that new wiper values have engaged
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            load_done_ff <= 1'b0;
        end else begin
            load_done_ff <= enable_fall;
        end
    end

    // Outputs straight from flops
    assign wiper_zero_code = zero_code_ff;
    assign wiper_one_code = one_code_ff;
    assign wiper_zero_terminal = zero_tap_ff;
    assign wiper_one_terminal = one_tap_ff;
    assign stack_select_bit = stack_ff;
    assign stacked_code = stacked_code_ff;
    assign stacked_from_one = stacked_from_one_ff;
    assign load_done = load_done_ff;

    ////////////////////////////////////////////////////////////////
    // Checks on the system clock side
    a_wiper_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !enable_fall |=> $stable(zero_code_ff) && $stable(one_code_ff))
        else $error("wiper code changed without an enable fall");

    a_wiper_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> zero_code_ff == $past(nxt_zero_code)
            && one_code_ff == $past(nxt_one_code))
        else $error("wiper codes not loaded from register");

    a_field_order: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> one_code_ff[7] == $past(shift_q[1])
            && zero_code_ff[0] == $past(shift_q[16]))
        else $error("wiper field bit order wrong");

    a_stack_mux: assert property (@(posedge clk) disable iff (!rst_b)
        load_done |-> stacked_code_ff == (stack_ff ? one_code_ff : zero_code_ff)
            && stacked_from_one_ff == stack_ff)
        else $error("stacked output selects the wrong wiper");

    a_tap_onehot: assert property (@(posedge clk) disable iff (!rst_b)
        $onehot(zero_tap_ff) && $onehot(one_tap_ff))
        else $error("tap select is not one-hot");

    a_tap_matches: assert property (@(posedge clk) disable iff (!rst_b)
        zero_tap_ff[zero_code_ff] && one_tap_ff[one_code_ff])
        else $error("tap select disagrees with code");

    a_fall_to_done: assert property (@(posedge clk) disable iff (!rst_b)
        enable_prev_ff && !enable_sync |=> load_done ##1 !load_done)
        else $error("load marker not a single pulse after fall");

    ////////////////////////////////////////////////////////////////
    // Hold checks: no loaded wiper, tap or stack output moves between loads
    a_tap_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !enable_fall |=> $stable(zero_tap_ff) && $stable(one_tap_ff))
        else $error("tap select changed without an enable fall");

    a_stack_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !enable_fall |=> $stable(stack_ff))
        else $error("stack bit changed without an enable fall");

    a_stacked_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !enable_fall |=> $stable(stacked_code_ff) && $stable(stacked_from_one_ff))
        else $error("stacked output changed without an enable fall");

    a_enabled_freeze: assert property (@(posedge clk) disable iff (!rst_b)
        enable_sync |=> $stable(zero_code_ff) && $stable(one_code_ff))
        else $error("wiper code moved while the port is enabled");

    a_enabled_tap_freeze: assert property (@(posedge clk) disable iff (!rst_b)
        enable_sync |=> $stable(zero_tap_ff) && $stable(one_tap_ff))
        else $error("tap select moved while the port is enabled");

    ////////////////////////////////////////////////////////////////
    // Load checks: every field lands from its own register positions
    a_stack_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> stack_ff == $past(shift_q[0]))
        else $error("stack bit not loaded from position 0");

    a_one_msb_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> one_code_ff[7] == $past(shift_q[1]))
        else $error("wiper one MSB not from position 1");

    a_one_lsb_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> one_code_ff[0] == $past(shift_q[8]))
        else $error("wiper one LSB not from position 8");

    a_zero_msb_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> zero_code_ff[7] == $past(shift_q[9]))
        else $error("wiper zero MSB not from position 9");

    a_zero_lsb_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> zero_code_ff[0] == $past(shift_q[16]))
        else $error("wiper zero LSB not from position 16");

    a_one_mid_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> one_code_ff[3] == $past(shift_q[5]))
        else $error("wiper one middle bit misplaced");

    a_zero_mid_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> zero_code_ff[3] == $past(shift_q[13]))
        else $error("wiper zero middle bit misplaced");

    ////////////////////////////////////////////////////////////////
    // Tap decode after a load picks exactly the loaded code
    a_zero_tap_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> zero_tap_ff == (256'h1 << $past(nxt_zero_code)))
        else $error("wiper zero tap not the loaded code");

    a_one_tap_load: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> one_tap_ff == (256'h1 << $past(nxt_one_code)))
        else $error("wiper one tap not the loaded code");

    ////////////////////////////////////////////////////////////////
    // Stacked selector for each value of the stack bit
    a_stacked_one: assert property (@(posedge clk) disable iff (!rst_b)
        load_done && stack_ff |-> stacked_code_ff == one_code_ff)
        else $error("stack bit 1 did not pick wiper one");

    a_stacked_zero: assert property (@(posedge clk) disable iff (!rst_b)
        load_done && !stack_ff |-> stacked_code_ff == zero_code_ff)
        else $error("stack bit 0 did not pick wiper zero");

    a_stacked_flag: assert property (@(posedge clk) disable iff (!rst_b)
        load_done |-> stacked_from_one == stack_select_bit)
        else $error("stacked source flag differs from stack bit");

    ////////////////////////////////////////////////////////////////
    // Load marker pulses once per fall and never otherwise
    a_done_after_fall: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> load_done)
        else $error("no load marker after enable fall");

    a_done_cause: assert property (@(posedge clk) disable iff (!rst_b)
        load_done |-> $past(enable_fall))
        else $error("load marker without an enable fall");

    a_done_single: assert property (@(posedge clk) disable iff (!rst_b)
        load_done |=> !load_done)
        else $error("load marker longer than one cycle");

    a_fall_isolated: assert property (@(posedge clk) disable iff (!rst_b)
        enable_fall |=> !enable_fall)
        else $error("enable fall seen on two cycles in a row");

    a_outputs_follow: assert property (@(posedge clk) disable iff (!rst_b)
        wiper_zero_code == zero_code_ff && wiper_one_code == one_code_ff)
        else $error("wiper code outputs differ from their flops");

endmodule

`default_nettype wire

// >>> core/pot_port_pkg.sv
// Constants shared by the dual wiper serial load port
// Overview of operation
// - Enable low: ignore clock, hold register
// - Enabled: shift data on rising clock
// - Eight-bit code picks one of 256 taps
// - Seventeen-bit register, position 0 stack select
// - Positions 1-8: wiper one code, MSB first
// - Positions 9-16: wiper zero code, MSB first
// - Order: stack bit, wiper one, wiper zero
// - Wipers load only when enable falls
// - Power-up wiper codes are arbitrary; reset here loads code 0 into both wipers
// - Stack bit 0 picks wiper zero, 1 wiper one
// - Cascade presents bit shifted out of end
// - First cascade bit is stored stack bit
// - Idle cascade shows current stack bit
// - Full circulation reloads original values
package pot_port_pkg;

    // Register geometry
    localparam int CODE_W = 8;
    localparam int SHIFT_LEN = 17;
    localparam int TAP_COUNT = 256;
    localparam int STACK_POS = 0;
    localparam int WIPER_ONE_MSB_POS = 1;
    localparam int WIPER_ZERO_MSB_POS = 9;

    // Reset values; the analog part starts arbitrary, zero is a safe pick
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [16:0] SHIFT_RESET = 17'h00000;
    localparam logic STACK_RESET = 1'b0;

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

endpackage

// >>> core/level_sync.sv
// Two-flop level synchroniser into a destination clock
`timescale 1ns/1ns
`default_nettype none

module level_sync (
    input wire logic dst_clk,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_ff;
    logic hold_ff;

    ////////////////////////////////////////////////////////////////
    // First stage is read only by the second
    always_ff @(posedge dst_clk) begin
        meta_ff <= async_in;
        hold_ff <= meta_ff;
    end

    assign sync_out = hold_ff;

endmodule

`default_nettype wire

// >>> core/link_shift_register.sv
// Seventeen-bit shift register on the serial clock, with cascade output
`timescale 1ns/1ns
`default_nettype none

module link_shift_register (
    input wire logic serial_clk,
    input wire logic link_rst_b,
    input wire logic serial_enable,
    input wire logic serial_data,
    output logic [16:0] shift_q,
    output logic cascade_out
);

    logic [16:0] shift_ff;

    ////////////////////////////////////////////////////////////////
    // Shift toward position 0; first bit sent lands in position 0
    always_ff @(posedge serial_clk) begin
        if (!link_rst_b) begin
            shift_ff <= pot_port_pkg::SHIFT_RESET;
        end else if (serial_enable) begin
            shift_ff <= {serial_data, shift_ff[16:1]};
        end
    end
    // Disabled edges fall through and leave the register alone

    assign shift_q = shift_ff;
    // Position 0 is both the stack bit and the bit leaving the end
    assign cascade_out = shift_ff[pot_port_pkg::STACK_POS];

    ////////////////////////////////////////////////////////////////
    // Checks on the link side
    default clocking link_cb @(posedge serial_clk); endclocking
    default disable iff (!link_rst_b);

    a_shift_hold_idle: assert property (!serial_enable |=> $stable(shift_ff))
        else $error("shift register moved while enable low");

    a_shift_data_in: assert property (serial_enable |=> shift_ff[16] == $past(serial_data))
        else $error("serial data not captured at the far end");

    a_cascade_next_bit: assert property (
        serial_enable |=> cascade_out == $past(shift_ff[1]))
        else $error("cascade did not present the next bit out");

    a_cascade_idle_stack: assert property (
        !serial_enable |-> cascade_out == shift_ff[pot_port_pkg::STACK_POS])
        else $error("idle cascade differs from stack bit");

    a_full_rotation: assert property (
        serial_enable && serial_data == shift_ff[0] |=> shift_ff[16] == $past(shift_ff[0]))
        else $error("fed-back bit not re-entered at the far end");

endmodule

`default_nettype wire

// >>> testbench/pot_host_model.sv
// Host model driving the three-wire serial load bus of the wiper port
`timescale 1ns/1ns
`default_nettype none

module pot_host_model (
    output logic serial_clk,
    output logic serial_enable,
    output logic serial_data,
    input wire logic cascade_out
);
    // Bus starts quiet: clock low, enable low
    initial begin
        serial_clk = 1'h0;
        serial_enable = 1'h0;
        serial_data = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock pulses with enable low; random data so any leak would show
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            serial_data <= 1'($urandom);
            #8 serial_clk <= 1'h1;
            #7 serial_clk <= 1'h0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // One framed transfer; cap[k] is the cascade level after k rising edges.
    // Data moves only after the falling edge, so setup before each rise holds.
    task automatic xfer(input logic [63:0] bits, input int n, input bit loop,
                        output logic [64:0] cap);
        cap = '0;
        serial_enable <= 1'h1;
        for (int k = 0; k < n; k++) begin
            // Read-back floats the line, so the cascade output feeds it
            serial_data <= loop ? cascade_out : bits[k];
            #8 cap[k] = cascade_out;
            serial_clk <= 1'h1;
            #7 serial_clk <= 1'h0;
        end
        #8 cap[n] = cascade_out;
        serial_enable <= 1'h0;
    endtask
endmodule

`default_nettype wire

// >>> testbench/dual_wiper_serial_shift_port_tb.sv
// Self-checking bench for the dual wiper serial load port
`timescale 1ns/1ns
`default_nettype none

module dual_wiper_serial_shift_port_tb;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    wire serial_clk;
    wire serial_enable;
    wire serial_data;
    logic cascade_out;
    logic [7:0] wiper_zero_code;
    logic [7:0] wiper_one_code;
    logic [255:0] wiper_zero_terminal;
    logic [255:0] wiper_one_terminal;
    logic stack_select_bit;
    logic [7:0] stacked_code;
    logic stacked_from_one;
    logic load_done;
    int failures = 0;
    int checks_done = 0;
    int loads = 0;
    // Expected register, position 0 is the stack bit
    logic [16:0] r = pot_port_pkg::SHIFT_RESET;

    always #20 clk = ~clk;

    // Count load pulses so a missing or doubled load is caught
    always @(posedge clk) begin
        if (load_done === 1'h1) loads <= loads + 1;
    end

    dual_wiper_serial_shift_port u_dut (.clk(clk), .rst_b(rst_b), .serial_clk(serial_clk),
        .serial_enable(serial_enable), .serial_data(serial_data), .cascade_out(cascade_out),
        .wiper_zero_code(wiper_zero_code), .wiper_one_code(wiper_one_code),
        .wiper_zero_terminal(wiper_zero_terminal), .wiper_one_terminal(wiper_one_terminal),
        .stack_select_bit(stack_select_bit), .stacked_code(stacked_code),
        .stacked_from_one(stacked_from_one), .load_done(load_done));

    pot_host_model u_host (.serial_clk(serial_clk), .serial_enable(serial_enable),
        .serial_data(serial_data), .cascade_out(cascade_out));

    ////////////////////////////////////////////////////////////////////////////
    // First listed position is the code MSB
    function automatic logic [7:0] code_of(input logic [16:0] v, input int msb);
        for (int i = 0; i < 8; i++) code_of[7 - i] = v[msb + i];
    endfunction

    task automatic check(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            failures++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask

    task automatic check_outputs;
        logic [7:0] w1;
        logic [7:0] w0;
        w1 = code_of(r, pot_port_pkg::WIPER_ONE_MSB_POS);
        w0 = code_of(r, pot_port_pkg::WIPER_ZERO_MSB_POS);
        check(wiper_one_code === w1 && wiper_zero_code === w0, "wiper codes");
        check(wiper_one_terminal === (256'h1 << w1), "tap one");
        check(wiper_zero_terminal === (256'h1 << w0), "tap zero");
        check(stack_select_bit === r[0] && stacked_from_one === r[0], "stack bit");
        check(stacked_code === (r[0] ? w1 : w0), "stacked code");
        check(cascade_out === r[0], "idle cascade");
    endtask

    // Transfer, then follow every cascade bit and the single load
    task automatic run(input int n, input bit loop, input logic [63:0] bits);
        logic [64:0] cap;
        logic [16:0] old;
        int c0;
        old = r;
        c0 = loads;
        u_host.xfer(bits, n, loop, cap);
        for (int k = 0; k <= n; k++) begin
            if (k > 0) r = {loop ? r[0] : bits[k - 1], r[16:1]};
            check(cap[k] === r[0], "cascade bit");
        end
        check(wiper_one_code === code_of(old, 1), "early load");
        for (int i = 0; i < 12 && loads == c0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        check(loads == c0 + 1, "one load");
        check_outputs();
    endtask

    task automatic results;
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: link clock must toggle while reset is held
    initial begin
        logic [16:0] corner [4] = '{17'h1FFFF, 17'h00000, 17'h00003, 17'h10100};
        int c0;
        void'($urandom(98));
        fork
            u_host.idle(20);
            begin
                repeat (5) @(posedge clk);
                rst_b <= 1'h1;
            end
        join
        u_host.idle(4);
        check(load_done === 1'h0 && loads == 0, "reset");
        check_outputs();
        foreach (corner[i]) run(17, 1'b0, {47'h0, corner[i]});
        repeat (6) run(17, 1'b0, {$urandom, $urandom});
        c0 = loads;
        u_host.idle(9);
        repeat (6) @(posedge clk);
        check(loads == c0, "idle load");
        check_outputs();
        run(34, 1'b0, {$urandom, $urandom});
        run(5, 1'b0, {$urandom, $urandom});
        run(17, 1'b1, 64'h0);
        results();
    end

    // Whole run is a few microseconds; this cuts a hang short
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule

`default_nettype wire
